/* File: rtl/dcc_pkg.sv */
package dcc_pkg;

  // printed register offsets, used as word indices
  localparam logic [31:0] DCC_IDX_SOFT_RESET = 32'h0f000040;
  localparam logic [31:0] DCC_IDX_IDLE       = 32'h0f000042;
  localparam logic [31:0] DCC_IDX_SEQ_EN     = 32'h0f000044;
  localparam logic [31:0] DCC_IDX_CHAN_EN    = 32'h0f000046;
  localparam logic [31:0] DCC_IDX_REQUEST    = 32'h0f000048;
  localparam logic [31:0] DCC_IDX_DIRECTION  = 32'h0f00004a;
  localparam logic [31:0] DCC_IDX_ARB_SEL    = 32'h0f00004c;
  localparam logic [31:0] DCC_IDX_CONTROL    = 32'h0f00004e;
  localparam logic [31:0] DCC_IDX_BCNT_LO    = 32'h0f000050;
  localparam logic [31:0] DCC_IDX_BCNT_HI    = 32'h0f000052;
  localparam logic [31:0] DCC_IDX_RCNT_LO    = 32'h0f000054;
  localparam logic [31:0] DCC_IDX_RCNT_HI    = 32'h0f000056;
  localparam logic [31:0] DCC_IDX_TC_IRQ     = 32'h0f000058;
  localparam logic [31:0] DCC_IDX_RBASE_LO   = 32'h0f0001e0;
  localparam logic [31:0] DCC_IDX_RBASE_HI   = 32'h0f0001e2;
  localparam logic [31:0] DCC_IDX_RNEXT_LO   = 32'h0f0001e4;
  localparam logic [31:0] DCC_IDX_RNEXT_HI   = 32'h0f0001e6;

  // byte addresses on the bus: four times the index
  localparam logic [31:0] DCC_A_SOFT_RESET = {DCC_IDX_SOFT_RESET[29:0], 2'b00};
  localparam logic [31:0] DCC_A_IDLE       = {DCC_IDX_IDLE[29:0], 2'b00};
  localparam logic [31:0] DCC_A_SEQ_EN     = {DCC_IDX_SEQ_EN[29:0], 2'b00};
  localparam logic [31:0] DCC_A_CHAN_EN    = {DCC_IDX_CHAN_EN[29:0], 2'b00};
  localparam logic [31:0] DCC_A_REQUEST    = {DCC_IDX_REQUEST[29:0], 2'b00};
  localparam logic [31:0] DCC_A_DIRECTION  = {DCC_IDX_DIRECTION[29:0], 2'b00};
  localparam logic [31:0] DCC_A_ARB_SEL    = {DCC_IDX_ARB_SEL[29:0], 2'b00};
  localparam logic [31:0] DCC_A_CONTROL    = {DCC_IDX_CONTROL[29:0], 2'b00};
  localparam logic [31:0] DCC_A_BCNT_LO    = {DCC_IDX_BCNT_LO[29:0], 2'b00};
  localparam logic [31:0] DCC_A_BCNT_HI    = {DCC_IDX_BCNT_HI[29:0], 2'b00};
  localparam logic [31:0] DCC_A_RCNT_LO    = {DCC_IDX_RCNT_LO[29:0], 2'b00};
  localparam logic [31:0] DCC_A_RCNT_HI    = {DCC_IDX_RCNT_HI[29:0], 2'b00};
  localparam logic [31:0] DCC_A_TC_IRQ     = {DCC_IDX_TC_IRQ[29:0], 2'b00};
  localparam logic [31:0] DCC_A_RBASE_LO   = {DCC_IDX_RBASE_LO[29:0], 2'b00};
  localparam logic [31:0] DCC_A_RBASE_HI   = {DCC_IDX_RBASE_HI[29:0], 2'b00};
  localparam logic [31:0] DCC_A_RNEXT_LO   = {DCC_IDX_RNEXT_LO[29:0], 2'b00};
  localparam logic [31:0] DCC_A_RNEXT_HI   = {DCC_IDX_RNEXT_HI[29:0], 2'b00};

  // channel bit positions (mask, request, grant)
  localparam int DCC_CH_FIR    = 0;
  localparam int DCC_CH_SER_RX = 1;
  localparam int DCC_CH_SER_TX = 2;
  localparam int DCC_CH_IO_RAM = 3;
  // direction and control field positions
  localparam int DCC_DIR_FIR_BIT   = 0;
  localparam int DCC_DIR_IO_BIT    = 1;
  localparam int DCC_CTL_AUTO_BIT  = 0;
  localparam int DCC_CTL_BLK_LSB   = 1;
  localparam int DCC_CTL_FIR_SPACE_EXTEND_BIT = 3;
  localparam int DCC_TC_BIT        = 0;

  // arbitration codes
  localparam logic [3:0] DCC_ARB_IO_RAM = 4'h8;
  localparam logic [3:0] DCC_ARB_SER_TX = 4'h4;
  localparam logic [3:0] DCC_ARB_SER_RX = 4'h2;
  localparam logic [3:0] DCC_ARB_FIR    = 4'h1;

  // block size codes and their size in 32-bit words
  localparam logic [1:0]  DCC_BLK_4B  = 2'h0;
  localparam logic [1:0]  DCC_BLK_16B = 2'h1;
  localparam logic [1:0]  DCC_BLK_32B = 2'h2;
  localparam logic [15:0] DCC_WORDS_4B  = 16'h0001;
  localparam logic [15:0] DCC_WORDS_16B = 16'h0004;
  localparam logic [15:0] DCC_WORDS_32B = 16'h0008;

  // reset values
  localparam logic [15:0] DCC_RST_RNEXT_LO = 16'hf800;
  localparam logic [15:0] DCC_RST_RNEXT_HI = 16'h01ff;
  localparam logic [15:0] DCC_RST_RBASE_LO = 16'h0000;
  localparam logic [15:0] DCC_RST_RBASE_HI = 16'h0000;

  // bus answers
  localparam logic [1:0] DCC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] DCC_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    DCC_ST_IDLE = 2'b01,
    DCC_ST_BUSY = 2'b10
  } dcc_state_e;

  typedef struct packed {
    dcc_state_e  state;
    logic [3:0]  grant;
    logic        to_mem;
    logic        soft_run;
    logic        seq_en;
    logic [3:0]  chan_en;
    logic        io_req;
    logic        fir_dir;
    logic        io_dir;
    logic [3:0]  arb;
    logic        fir_ext;
    logic [1:0]  blk;
    logic        auto_rl;
    logic [15:0] byte_cnt;
    logic [15:0] remain;
    logic [24:0] ram_base;
    logic [24:0] ram_next;
    logic        tc;
    logic        aw_got;
    logic        w_got;
    logic [31:0] awaddr;
    logic [15:0] wdata;
    logic [1:0]  wstrb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [15:0] rdata;
    logic [1:0]  rresp;
  } dcc_regs_s;

  // byte-lane merge of a write into a 16-bit register
  function automatic logic [15:0] dcc_merge(input logic [15:0] old_v,
                                            input logic [15:0] new_v,
                                            input logic [1:0]  strb);
    logic [15:0] res;
    res = old_v;
    if (strb[0]) begin
      res[7:0] = new_v[7:0];
    end
    if (strb[1]) begin
      res[15:8] = new_v[15:8];
    end
    return res;
  endfunction

endpackage

/* File: rtl/dcc_arbiter.sv */
`timescale 1ns/10ps
`default_nettype none
module dcc_arbiter
  import dcc_pkg::*;
(
  input  wire logic [3:0] req,
  input  wire logic [3:0] sel,
  output var  logic [3:0] win
);

  logic [3:0] top;

  // favoured channel from the selection code
  always_comb begin
    case (sel)
      DCC_ARB_IO_RAM: top = 4'h8;
      DCC_ARB_SER_TX: top = 4'h4;
      DCC_ARB_SER_RX: top = 4'h2;
      DCC_ARB_FIR:    top = 4'h1;
      default:        top = 4'h0;
    endcase
  end

  // favoured channel first, then fir, rx, tx, io-ram
  always_comb begin
    if ((top & req) != 4'h0) begin
      win = top;
    end else if (req[DCC_CH_FIR]) begin
      win = 4'h1;
    end else if (req[DCC_CH_SER_RX]) begin
      win = 4'h2;
    end else if (req[DCC_CH_SER_TX]) begin
      win = 4'h4;
    end else if (req[DCC_CH_IO_RAM]) begin
      win = 4'h8;
    end else begin
      win = 4'h0;
    end
  end

endmodule
`default_nettype wire

/* File: rtl/dcc_top.sv */
// Function
// - software writing one to io_ram_request starts the io-ram channel
// - at terminal count without auto reload, io_ram_request clears itself
// - writing zero stops the channel after the block in progress
// - read-only pending bits show fir, serial tx and rx requests
// - direction bit one selects io-ram transfer from external io to memory
// - direction bit zero selects fir transfer from internal unit to memory
// - arbitration codes 1000, 0100, 0010, 0001 favour one channel
// - other arbitration codes use fixed order fir, rx, tx, io-ram
// - fir_space_extend chooses two 2 KB or two 1 KB pages
// - block_size_sel chooses 32, 16 or 4 byte blocks; 11 reserved
// - auto reload restores next address from base and keeps running
// - byte count is 18 bits, word aligned, split over two registers
// - remaining count is 18-bit read/write, tracks untransferred bytes
// - terminal_count_flag reads one while terminal count is pending
// - pending terminal count drives the bus unit interrupt output
// - reserved bits are written zero and always read zero
// - controller_soft_reset at zero holds the controller in reset
// - sequencer_enable at one enables all channels, zero disables
// - per-channel enable bits gate each channel including io-ram
// - read-only next address shows the io-ram channel ram address
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
module dcc_top
  import dcc_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        RST_N,
  input  wire logic [31:0] AWADDR,
  input  wire logic        AWVALID,
  output var  logic        AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output var  logic        WREADY,
  output var  logic [1:0]  BRESP,
  output var  logic        BVALID,
  input  wire logic        BREADY,
  input  wire logic [31:0] ARADDR,
  input  wire logic        ARVALID,
  output var  logic        ARREADY,
  output var  logic [31:0] RDATA,
  output var  logic [1:0]  RRESP,
  output var  logic        RVALID,
  input  wire logic        RREADY,
  input  wire logic        FIR_REQ,
  input  wire logic        SER_RX_REQ,
  input  wire logic        SER_TX_REQ,
  input  wire logic        BUS_DONE,
  output var  logic [3:0]  GRANT,
  output var  logic        XFER_TO_MEM,
  output var  logic [1:0]  BLOCK_SIZE_SEL,
  output var  logic        FIR_SPACE_EXTEND,
  output var  logic [26:0] RAM_NEXT_ADDR,
  output var  logic        BUS_UNIT_IRQ
);

  dcc_regs_s   st_ff;
  dcc_regs_s   nxt_st;
  logic [3:0]  chan_req;
  logic [3:0]  chan_win;
  logic [15:0] blk_words;
  logic [15:0] wr_val;
  logic [15:0] rd_val;
  logic        rd_ok;
  logic        do_write;

  // channel requests gated by the enables
  always_comb begin
    chan_req[DCC_CH_FIR]    = FIR_REQ & st_ff.chan_en[DCC_CH_FIR];
    chan_req[DCC_CH_SER_RX] = SER_RX_REQ & st_ff.chan_en[DCC_CH_SER_RX];
    chan_req[DCC_CH_SER_TX] = SER_TX_REQ & st_ff.chan_en[DCC_CH_SER_TX];
    chan_req[DCC_CH_IO_RAM] = st_ff.io_req
                              & st_ff.chan_en[DCC_CH_IO_RAM];
    if (!st_ff.seq_en) begin
      chan_req = 4'h0;
    end
  end

  dcc_arbiter u_arb (
    .req (chan_req),
    .sel (st_ff.arb),
    .win (chan_win)
  );

  // words per block from the size code
  always_comb begin
    case (st_ff.blk)
      DCC_BLK_32B: blk_words = DCC_WORDS_32B;
      DCC_BLK_16B: blk_words = DCC_WORDS_16B;
      DCC_BLK_4B:  blk_words = DCC_WORDS_4B;
      default:     blk_words = DCC_WORDS_4B;
    endcase
  end

  // register read decode
  always_comb begin
    rd_val = 16'h0000;
    rd_ok  = 1'b1;
    case (ARADDR)
      DCC_A_SOFT_RESET: rd_val[0] = st_ff.soft_run;
      DCC_A_IDLE:       rd_val[0] = (st_ff.state == DCC_ST_IDLE);
      DCC_A_SEQ_EN:     rd_val[0] = st_ff.seq_en;
      DCC_A_CHAN_EN:    rd_val[3:0] = st_ff.chan_en;
      DCC_A_REQUEST: begin
        rd_val[DCC_CH_IO_RAM] = st_ff.io_req;
        rd_val[DCC_CH_SER_TX] = SER_TX_REQ;
        rd_val[DCC_CH_SER_RX] = SER_RX_REQ;
        rd_val[DCC_CH_FIR]    = FIR_REQ;
      end
      DCC_A_DIRECTION: begin
        rd_val[DCC_DIR_IO_BIT]  = st_ff.io_dir;
        rd_val[DCC_DIR_FIR_BIT] = st_ff.fir_dir;
      end
      DCC_A_ARB_SEL:    rd_val[3:0] = st_ff.arb;
      DCC_A_CONTROL: begin
        rd_val[DCC_CTL_FIR_SPACE_EXTEND_BIT] = st_ff.fir_ext;
        rd_val[DCC_CTL_BLK_LSB+:2] = st_ff.blk;
        rd_val[DCC_CTL_AUTO_BIT]  = st_ff.auto_rl;
      end
      DCC_A_BCNT_LO:    rd_val = {st_ff.byte_cnt[13:0], 2'b00};
      DCC_A_BCNT_HI:    rd_val[1:0] = st_ff.byte_cnt[15:14];
      DCC_A_RCNT_LO:    rd_val = {st_ff.remain[13:0], 2'b00};
      DCC_A_RCNT_HI:    rd_val[1:0] = st_ff.remain[15:14];
      DCC_A_TC_IRQ:     rd_val[DCC_TC_BIT] = st_ff.tc;
      DCC_A_RBASE_LO:   rd_val = {st_ff.ram_base[13:0], 2'b00};
      DCC_A_RBASE_HI:   rd_val[10:0] = st_ff.ram_base[24:14];
      DCC_A_RNEXT_LO:   rd_val = {st_ff.ram_next[13:0], 2'b00};
      DCC_A_RNEXT_HI:   rd_val[10:0] = st_ff.ram_next[24:14];
      default:          rd_ok = 1'b0;
    endcase
  end

  // next state: bus slave, register writes, then the sequencer
  always_comb begin
    nxt_st   = st_ff;
    do_write = st_ff.aw_got & st_ff.w_got & ~st_ff.bvalid;
    wr_val   = 16'h0000;

    // write address and data taken in either order
    if (AWVALID && st_ff.awready) begin
      nxt_st.aw_got = 1'b1;
      nxt_st.awaddr = AWADDR;
    end
    if (WVALID && st_ff.wready) begin
      nxt_st.w_got = 1'b1;
      nxt_st.wdata = WDATA[15:0];
      nxt_st.wstrb = WSTRB[1:0];
    end
    if (st_ff.bvalid && BREADY) begin
      nxt_st.bvalid = 1'b0;
    end

    // register writes; reserved bits are never stored
    if (do_write) begin
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got  = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp  = DCC_RESP_OKAY;
      case (st_ff.awaddr)
        DCC_A_SOFT_RESET: begin
          wr_val = dcc_merge(16'h0000, st_ff.wdata, st_ff.wstrb);
          if (st_ff.wstrb[0]) begin
            nxt_st.soft_run = wr_val[0];
          end
        end
        DCC_A_SEQ_EN: begin
          if (st_ff.wstrb[0]) begin
            nxt_st.seq_en = st_ff.wdata[0];
          end
        end
        DCC_A_CHAN_EN: begin
          if (st_ff.wstrb[0]) begin
            nxt_st.chan_en = st_ff.wdata[3:0];
          end
        end
        DCC_A_REQUEST: begin
          if (st_ff.wstrb[0]) begin
            nxt_st.io_req = st_ff.wdata[DCC_CH_IO_RAM];
            if (st_ff.wdata[DCC_CH_IO_RAM] && !st_ff.io_req) begin
              nxt_st.remain   = st_ff.byte_cnt;
              nxt_st.ram_next = st_ff.ram_base;
            end
          end
        end
        DCC_A_DIRECTION: begin
          if (st_ff.wstrb[0]) begin
            nxt_st.io_dir  = st_ff.wdata[DCC_DIR_IO_BIT];
            nxt_st.fir_dir = st_ff.wdata[DCC_DIR_FIR_BIT];
          end
        end
        DCC_A_ARB_SEL: begin
          if (st_ff.wstrb[0]) begin
            nxt_st.arb = st_ff.wdata[3:0];
          end
        end
        DCC_A_CONTROL: begin
          if (st_ff.wstrb[0]) begin
            nxt_st.fir_ext = st_ff.wdata[DCC_CTL_FIR_SPACE_EXTEND_BIT];
            nxt_st.blk     = st_ff.wdata[DCC_CTL_BLK_LSB+:2];
            nxt_st.auto_rl = st_ff.wdata[DCC_CTL_AUTO_BIT];
          end
        end
        DCC_A_BCNT_LO: begin
          wr_val = dcc_merge({st_ff.byte_cnt[13:0], 2'b00},
                             st_ff.wdata, st_ff.wstrb);
          nxt_st.byte_cnt[13:0] = wr_val[15:2];
        end
        DCC_A_BCNT_HI: begin
          if (st_ff.wstrb[0]) begin
            nxt_st.byte_cnt[15:14] = st_ff.wdata[1:0];
          end
        end
        DCC_A_RCNT_LO: begin
          wr_val = dcc_merge({st_ff.remain[13:0], 2'b00},
                             st_ff.wdata, st_ff.wstrb);
          nxt_st.remain[13:0] = wr_val[15:2];
        end
        DCC_A_RCNT_HI: begin
          if (st_ff.wstrb[0]) begin
            nxt_st.remain[15:14] = st_ff.wdata[1:0];
          end
        end
        DCC_A_TC_IRQ: begin
          if (st_ff.wstrb[0] && !st_ff.wdata[DCC_TC_BIT]) begin
            nxt_st.tc = 1'b0;
          end
        end
        DCC_A_RBASE_LO: begin
          wr_val = dcc_merge({st_ff.ram_base[13:0], 2'b00},
                             st_ff.wdata, st_ff.wstrb);
          nxt_st.ram_base[13:0] = wr_val[15:2];
        end
        DCC_A_RBASE_HI: begin
          wr_val = dcc_merge({5'h00, st_ff.ram_base[24:14]},
                             st_ff.wdata, st_ff.wstrb);
          nxt_st.ram_base[24:14] = wr_val[10:0];
        end
        DCC_A_IDLE, DCC_A_RNEXT_LO, DCC_A_RNEXT_HI: begin
          nxt_st.bresp = DCC_RESP_OKAY;
        end
        default: nxt_st.bresp = DCC_RESP_SLVERR;
      endcase
    end

    // sequencer: grant a channel, hold it until the block ends
    case (st_ff.state)
      DCC_ST_IDLE: begin
        if (chan_win != 4'h0) begin
          nxt_st.grant = chan_win;
          nxt_st.state = DCC_ST_BUSY;
          case (chan_win)
            4'h8:    nxt_st.to_mem = st_ff.io_dir;
            4'h1:    nxt_st.to_mem = st_ff.fir_dir;
            4'h2:    nxt_st.to_mem = 1'b1;
            default: nxt_st.to_mem = 1'b0;
          endcase
        end
      end
      DCC_ST_BUSY: begin
        // a cleared request only takes effect once this block ends
        if (BUS_DONE) begin
          nxt_st.grant = 4'h0;
          nxt_st.state = DCC_ST_IDLE;
          if (st_ff.grant[DCC_CH_IO_RAM]) begin
            nxt_st.ram_next = st_ff.ram_next + {9'h000, blk_words};
            // short count saturates to zero
            if (st_ff.remain <= blk_words) begin
              nxt_st.remain = 16'h0000;
              nxt_st.tc     = 1'b1;
              if (st_ff.auto_rl) begin
                nxt_st.ram_next = st_ff.ram_base;
                nxt_st.remain   = st_ff.byte_cnt;
              end else begin
                nxt_st.io_req = 1'b0;
              end
            end else begin
              nxt_st.remain = st_ff.remain - blk_words;
            end
          end
        end
      end
      default: begin
        nxt_st.state = DCC_ST_IDLE;
        nxt_st.grant = 4'h0;
      end
    endcase

    // soft reset holds the sequencer and io-ram request cleared
    if (!st_ff.soft_run) begin
      nxt_st.state  = DCC_ST_IDLE;
      nxt_st.grant  = 4'h0;
      nxt_st.io_req = 1'b0;
    end

    // read channel
    if (st_ff.rvalid && RREADY) begin
      nxt_st.rvalid = 1'b0;
    end
    if (ARVALID && st_ff.arready) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata  = rd_val;
      nxt_st.rresp  = rd_ok ? DCC_RESP_OKAY : DCC_RESP_SLVERR;
    end

    // ready flags follow the holding state
    nxt_st.awready = ~nxt_st.aw_got;
    nxt_st.wready  = ~nxt_st.w_got;
    nxt_st.arready = ~nxt_st.rvalid;
  end

  // state register with synchronous reset
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      st_ff          <= '0;
      st_ff.state    <= DCC_ST_IDLE;
      st_ff.ram_next <= {DCC_RST_RNEXT_HI[10:0], DCC_RST_RNEXT_LO[15:2]};
      st_ff.ram_base <= {DCC_RST_RBASE_HI[10:0], DCC_RST_RBASE_LO[15:2]};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from the state register
  assign AWREADY          = st_ff.awready;
  assign WREADY           = st_ff.wready;
  assign BVALID           = st_ff.bvalid;
  assign BRESP            = st_ff.bresp;
  assign ARREADY          = st_ff.arready;
  assign RVALID           = st_ff.rvalid;
  assign RRESP            = st_ff.rresp;
  assign RDATA            = {16'h0000, st_ff.rdata};
  assign GRANT            = st_ff.grant;
  assign XFER_TO_MEM      = st_ff.to_mem;
  assign BLOCK_SIZE_SEL   = st_ff.blk;
  assign FIR_SPACE_EXTEND = st_ff.fir_ext;
  assign RAM_NEXT_ADDR    = {st_ff.ram_next, 2'b00};
  assign BUS_UNIT_IRQ     = st_ff.tc;

endmodule
`default_nettype wire

/* File: bench/dcc_top_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
module dcc_top_asserts
  import dcc_pkg::*;
(
  input wire logic        CLOCK,
  input wire logic        RST_N,
  input wire logic        RVALID,
  input wire logic [31:0] RDATA,
  input wire logic        BVALID,
  input wire logic        BUS_DONE,
  input wire logic [3:0]  GRANT,
  input wire logic [26:0] RAM_NEXT_ADDR,
  input wire logic        BUS_UNIT_IRQ
);
  // all checks on the bus clock, idle in reset except reset_state_a
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  // outputs after a reset edge
  reset_state_a:
    assert property (disable iff (1'b0)
      !RST_N |=> GRANT == 4'h0 && RAM_NEXT_ADDR == 27'h1fff800)
    else $error("grant or next address wrong after reset");
  grant_onehot_a:
    assert property ($onehot0(GRANT))
    else $error("more than one channel granted");
  // a block in progress runs to its end unless a register write stops it
  grant_hold_a:
    assert property (GRANT != 4'h0 && !BUS_DONE |=>
      $stable(GRANT) || (GRANT == 4'h0 && $rose(BVALID)))
    else $error("grant changed before block done");
  grant_end_a:
    assert property (GRANT != 4'h0 && BUS_DONE |=> GRANT == 4'h0)
    else $error("grant kept after block done");
  irq_cause_a:
    assert property ($rose(BUS_UNIT_IRQ) |->
      $past(GRANT[DCC_CH_IO_RAM]) && $past(BUS_DONE))
    else $error("interrupt without io-ram block end");
  irq_clear_a:
    assert property ($fell(BUS_UNIT_IRQ) |-> BVALID || $past(BVALID))
    else $error("interrupt dropped without a write");
  ram_align_a:
    assert property (RAM_NEXT_ADDR[1:0] == 2'b00)
    else $error("next address not word aligned");
  rdata_upper_a:
    assert property (RVALID |-> RDATA[31:16] == 16'h0000)
    else $error("upper read data not zero");
endmodule
bind dcc_top dcc_top_asserts u_chk (.CLOCK(CLOCK), .RST_N(RST_N),
  .RVALID(RVALID), .RDATA(RDATA), .BVALID(BVALID), .BUS_DONE(BUS_DONE),
  .GRANT(GRANT), .RAM_NEXT_ADDR(RAM_NEXT_ADDR), .BUS_UNIT_IRQ(BUS_UNIT_IRQ));
`default_nettype wire

/* File: bench/dcc_periph_model.sv */
`timescale 1ns/10ps
`default_nettype none
module dcc_periph_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [2:0] want,
  input  wire logic       slow,
  input  wire logic [3:0] grant,
  output var  logic [2:0] req,
  output var  logic       done
);
  logic [3:0] age_ff;
  // peripheral requests are levels set by the bench
  assign req = want;
  // bus ends each granted block after a short or long wait
  always_ff @(posedge clk) begin
    if (!rst_n || grant == 4'h0) begin
      age_ff <= 4'h0;
      done   <= 1'b0;
    end else begin
      age_ff <= age_ff + 4'h1;
      done   <= (age_ff == (slow ? 4'h9 : 4'h1));
    end
  end
endmodule
`default_nettype wire

/* File: bench/dma_channel_control_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
  $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module dma_channel_control_tb
  import dcc_pkg::*;
;
  typedef struct {logic [31:0] a; logic [15:0] e; logic [1:0] r;} dcc_row_s;
  logic        clock, rst_n, awvalid, wvalid, bready, arvalid, rready, slow;
  logic        awready, wready, bvalid, arready, rvalid, done, tomem, fx, irq;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [1:0]  bresp, rresp, blk, bresp_q, rresp_q;
  logic [2:0]  want, req;
  logic [3:0]  grant;
  logic [26:0] rnext;
  logic [15:0] rd_q;
  int          err_count, num_checks, cycles, i;
  logic [3:0]  codes [6] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'h0, 4'hf};
  logic [3:0]  wins [6] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'h1, 4'h1};
  logic        dirs [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
  dcc_row_s    rows [13] = '{
    '{DCC_A_SOFT_RESET, 16'h0001, DCC_RESP_OKAY},
    '{DCC_A_SEQ_EN, 16'h0001, DCC_RESP_OKAY},
    '{DCC_A_CHAN_EN, 16'h000f, DCC_RESP_OKAY},
    '{DCC_A_DIRECTION, 16'h0003, DCC_RESP_OKAY},
    '{DCC_A_ARB_SEL, 16'h000f, DCC_RESP_OKAY},
    '{DCC_A_CONTROL, 16'h000f, DCC_RESP_OKAY},
    '{DCC_A_BCNT_LO, 16'hfffc, DCC_RESP_OKAY},
    '{DCC_A_BCNT_HI, 16'h0003, DCC_RESP_OKAY},
    '{DCC_A_RCNT_LO, 16'hfffc, DCC_RESP_OKAY},
    '{DCC_A_RCNT_HI, 16'h0003, DCC_RESP_OKAY},
    '{DCC_A_RBASE_LO, 16'hfffc, DCC_RESP_OKAY},
    '{DCC_A_RBASE_HI, 16'h07ff, DCC_RESP_OKAY},
    '{32'h3c000200, 16'h0000, DCC_RESP_SLVERR}};

  dcc_top dut (.CLOCK(clock), .RST_N(rst_n), .AWADDR(awaddr),
    .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hf),
    .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
    .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
    .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
    .FIR_REQ(req[0]), .SER_RX_REQ(req[1]), .SER_TX_REQ(req[2]),
    .BUS_DONE(done), .GRANT(grant), .XFER_TO_MEM(tomem),
    .BLOCK_SIZE_SEL(blk), .FIR_SPACE_EXTEND(fx), .RAM_NEXT_ADDR(rnext),
    .BUS_UNIT_IRQ(irq));
  dcc_periph_model far (.clk(clock), .rst_n(rst_n), .want(want),
    .slow(slow), .grant(grant), .req(req), .done(done));

  // bus clock and hang guard
  always #12.5 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      results();
    end
  end

  // one register write, address and data offered together
  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    awaddr  <= a;
    wdata   <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    // bready stays high, so back to back writes never see one response twice
    bresp_q = bresp;
  endtask
  // one register read, compared with data and answer code
  task automatic rdc(input logic [31:0] a, input logic [15:0] e,
                     input logic [1:0] r);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd_q = rdata[15:0];
    rresp_q = rresp;
    `CHK(rd_q, e)
    `CHK(rresp_q, r)
  endtask
  task automatic wt_grant();
    do @(posedge clock); while (grant === 4'h0);
  endtask
  task automatic wt_idle();
    repeat (3) @(posedge clock);
    while (grant !== 4'h0) @(posedge clock);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // main sequence
  initial begin
    {clock, rst_n, awvalid, wvalid, bready, arvalid, rready, slow} = 8'h00;
    {awaddr, wdata, araddr, want} = '0;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rdc(DCC_A_RNEXT_LO, 16'hf800, DCC_RESP_OKAY);
    rdc(DCC_A_RNEXT_HI, 16'h01ff, DCC_RESP_OKAY);
    for (i = 0; i < 13; i++) begin
      rdc(rows[i].a, 16'h0000, rows[i].r);
      wr(rows[i].a, 16'hffff);
      `CHK(bresp_q, rows[i].r)
      rdc(rows[i].a, rows[i].e, rows[i].r);
    end
    `CHK(blk, 2'h3)
    `CHK(fx, 1'b1)
    wr(DCC_A_DIRECTION, 16'h0001);
    for (i = 0; i < 6; i++) begin
      wr(DCC_A_CHAN_EN, 16'h0000);
      wr(DCC_A_ARB_SEL, {12'h000, codes[i]});
      wr(DCC_A_REQUEST, 16'h0008);
      want <= 3'h7;
      rdc(DCC_A_REQUEST, 16'h000f, DCC_RESP_OKAY);
      `CHK(grant, 4'h0)
      wr(DCC_A_CHAN_EN, 16'h000f);
      wt_grant();
      `CHK(grant, wins[i])
      `CHK(tomem, dirs[i])
      want <= 3'h0;
      wr(DCC_A_REQUEST, 16'h0000);
      wt_idle();
    end
    // two 16-byte blocks to memory, then terminal count
    slow <= 1'b1;
    wr(DCC_A_DIRECTION, 16'h0002);
    wr(DCC_A_CONTROL, 16'h0002);
    `CHK(blk, DCC_BLK_16B)
    `CHK(fx, 1'b0)
    wr(DCC_A_BCNT_LO, 16'h0020);
    wr(DCC_A_BCNT_HI, 16'h0000);
    wr(DCC_A_RBASE_LO, 16'h0100);
    wr(DCC_A_RBASE_HI, 16'h0000);
    wr(DCC_A_REQUEST, 16'h0008);
    wt_grant();
    `CHK(tomem, 1'b1)
    `CHK(rnext, 27'h0000100)
    rdc(DCC_A_RCNT_LO, 16'h0020, DCC_RESP_OKAY);
    while (grant !== 4'h0) @(posedge clock);
    rdc(DCC_A_RCNT_LO, 16'h0010, DCC_RESP_OKAY);
    while (irq !== 1'b1) @(posedge clock);
    `CHK(rnext, 27'h0000120)
    rdc(DCC_A_REQUEST, 16'h0000, DCC_RESP_OKAY);
    rdc(DCC_A_TC_IRQ, 16'h0001, DCC_RESP_OKAY);
    wr(DCC_A_TC_IRQ, 16'h0000);
    rdc(DCC_A_TC_IRQ, 16'h0000, DCC_RESP_OKAY);
    `CHK(irq, 1'b0)
    // one 32-byte block with reload, then a forced stop
    wr(DCC_A_CONTROL, 16'h0005);
    wr(DCC_A_REQUEST, 16'h0008);
    while (irq !== 1'b1) @(posedge clock);
    `CHK(rnext, 27'h0000100)
    rdc(DCC_A_REQUEST, 16'h0008, DCC_RESP_OKAY);
    wr(DCC_A_REQUEST, 16'h0000);
    wt_idle();
    repeat (12) @(posedge clock);
    `CHK(grant, 4'h0)
    wr(DCC_A_TC_IRQ, 16'h0000);
    // eight 4-byte blocks without reload
    wr(DCC_A_CONTROL, 16'h0000);
    `CHK(blk, DCC_BLK_4B)
    wr(DCC_A_REQUEST, 16'h0008);
    while (irq !== 1'b1) @(posedge clock);
    `CHK(rnext, 27'h0000120)
    wr(DCC_A_TC_IRQ, 16'h0000);
    // controller held, then sequencer off, then running
    wr(DCC_A_SOFT_RESET, 16'h0000);
    want <= 3'h1;
    repeat (8) @(posedge clock);
    `CHK(grant, 4'h0)
    wr(DCC_A_SEQ_EN, 16'h0000);
    wr(DCC_A_SOFT_RESET, 16'h0001);
    repeat (8) @(posedge clock);
    `CHK(grant, 4'h0)
    wr(DCC_A_SEQ_EN, 16'h0001);
    wt_grant();
    `CHK(grant, 4'h1)
    `CHK(tomem, 1'b0)
    results();
  end
endmodule
`default_nettype wire
